// ==== rtl/adc_cfg_bank.sv ====
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "adc_cfg_regs.svh"
module adc_cfg_bank
(
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // wishbone classic slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [15:0]              wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // external shutdown pin
  input  wire logic                     shutdown_pin_i,
  // converter controls
  output adc_cfg_pkg::chan_ctrl_s       chan_ctrl_o,
  output logic                          converter_standby_o,
  output logic                          global_shutdown_o,
  output logic      [7:0]               swing_code_o,
  output logic                          sample_en_o,
  output logic      [7:0]               high_if_mode_o,
  output logic                          sync_ref_buffer_off_o
);

  // ****************************************************************
  // register indices per channel
  // ****************************************************************

  // channel order in these tables is a, b, c, d
  localparam logic [`IDX_W-1:0] CHOP_IDX  [4] = '{`REG_CHOP_A, `REG_CHOP_B,
                                                  `REG_CHOP_C, `REG_CHOP_D};
  localparam logic [`IDX_W-1:0] DITH_IDX  [4] = '{`REG_DITH_A, `REG_DITH_B,
                                                  `REG_DITH_C, `REG_DITH_D};
  localparam logic [`IDX_W-1:0] TWEAK_IDX [4] = '{`REG_TWEAK_A, `REG_TWEAK_B,
                                                  `REG_TWEAK_C, `REG_TWEAK_D};
  // single high-if bits, tuning bits 0..3
  localparam logic [`IDX_W-1:0] HIF_IDX   [4] = '{`REG_HIF_BIT0, `REG_HIF_BIT1,
                                                  `REG_HIF_BIT2, `REG_HIF_BIT3};

  // ****************************************************************
  // state
  // ****************************************************************

  adc_cfg_pkg::bank_state_s st_r;
  adc_cfg_pkg::bank_state_s st_nxt;

  logic                     div_tick;

  // ****************************************************************
  // next state
  // ****************************************************************

  // bus decode, register updates and the derived controls
  always_comb
  begin
    logic [`IDX_W-1:0] idx;
    logic [7:0]        wdata;
    logic [7:0]        rd;
    logic              access;
    logic              wr;
    logic [1:0]        pair;
    logic              pin_func;

    idx      = wb_adr_i[`IDX_W+1:2];
    wdata    = wb_dat_i[7:0];
    rd       = `CFG_RESET_VAL;
    access   = wb_cyc_i & wb_stb_i & ~st_r.ack;
    // only byte lane 0 carries data, other lanes are ignored
    wr       = access & wb_we_i & wb_sel_i[0];
    pair     = 2'h0;
    pin_func = st_r.cfg.pwr[`PWR_PIN_FUNC_BIT];
    st_nxt   = st_r;

    // classic handshake: ack one cycle, dropped after it was seen
    st_nxt.ack = access;

    // --- registers outside the channel pages ---
    case (idx)
      `REG_PWR_CTRL:
      begin
        // channel a and d bits are write only and read as zero
        rd = st_r.cfg.pwr & `PWR_READ_MASK;
        if (wr)
          st_nxt.cfg.pwr = wdata & `PWR_WRITE_MASK;
      end
      `REG_SWING:
      begin
        rd = st_r.cfg.swing;
        if (wr)
          st_nxt.cfg.swing = wdata;
      end
      `REG_CLK_DIV:
      begin
        rd[`CLK_DIV_LSB +: 2] = st_r.cfg.clk_div;
        if (wr)
          st_nxt.cfg.clk_div = adc_cfg_pkg::clk_div_e'(wdata[`CLK_DIV_LSB +: 2]);
      end
      `REG_DITHER_PAIR:
      begin
        rd = st_r.cfg.dith_pair;
        if (wr)
          st_nxt.cfg.dith_pair = wdata;
      end
      `REG_HIF_PAIR_LO:
      begin
        // this pair is write only, reads return zero
        if (wr)
          st_nxt.cfg.high_if[5:4] = wdata[`HIF_PAIR_LSB +: 2];
      end
      `REG_HIF_PAIR_HI:
      begin
        rd[`HIF_PAIR_LSB +: 2] = st_r.cfg.high_if[7:6];
        if (wr)
          st_nxt.cfg.high_if[7:6] = wdata[`HIF_PAIR_LSB +: 2];
      end
      `REG_SYNC_REF:
      begin
        rd[`SYNC_OFF_BIT] = st_r.cfg.sync_off;
        if (wr)
          st_nxt.cfg.sync_off = wdata[`SYNC_OFF_BIT];
      end
      default:
      begin
        // unmapped indices read as zero and ignore writes
        rd = rd;
      end
    endcase

    // --- per-channel registers, one of each kind per channel ---
    for (int c = 0; c < 4; c++)
    begin
      if (idx == CHOP_IDX[c])
      begin
        rd[`CHOP_BIT] = st_r.cfg.chop[c];
        if (wr)
          st_nxt.cfg.chop[c] = wdata[`CHOP_BIT];
      end
      if (idx == DITH_IDX[c])
      begin
        rd[`DITH_HI_BIT] = st_r.cfg.dith_hi[c];
        rd[`DITH_LO_BIT] = st_r.cfg.dith_lo[c];
        if (wr)
        begin
          st_nxt.cfg.dith_hi[c] = wdata[`DITH_HI_BIT];
          st_nxt.cfg.dith_lo[c] = wdata[`DITH_LO_BIT];
        end
      end
      if (idx == TWEAK_IDX[c])
      begin
        rd[`TWEAK_BIT] = st_r.cfg.tweak[c];
        if (wr)
          st_nxt.cfg.tweak[c] = wdata[`TWEAK_BIT];
      end
      if (idx == HIF_IDX[c])
      begin
        rd[`HIF_SINGLE_BIT] = st_r.cfg.high_if[c];
        if (wr)
          st_nxt.cfg.high_if[c] = wdata[`HIF_SINGLE_BIT];
      end
    end

    // software reset wins over any other update and never reads back,
    // so the bit behaves as self-clearing
    if (wr && idx == `REG_SOFT_RESET && wdata[`SOFT_RESET_BIT])
      st_nxt.cfg = '0;

    // read data is captured with the ack and held until the next access
    if (access)
      st_nxt.rdata = rd;

    // --- controls derived from the stored configuration ---
    for (int c = 0; c < 4; c++)
    begin
      // channel a sits at bit 7, then b, c, d downwards
      st_nxt.chan.shutdown[c]    = st_r.cfg.pwr[`PWR_CHAN_A_BIT - c];
      st_nxt.chan.chopper_off[c] = st_r.cfg.chop[c];
      st_nxt.chan.perf_tweak[c]  = st_r.cfg.tweak[c];
      // companion pair: a at bits 7-6 down to d at bits 1-0
      pair = st_r.cfg.dith_pair[6 - 2 * c +: 2];
      // any partial pattern keeps dither on, only all ones disables it
      st_nxt.chan.dither_off[c]  = st_r.cfg.dith_hi[c] & st_r.cfg.dith_lo[c]
                                   & (&pair);
    end

    // the pin adds to the register bits, its meaning set by the function bit
    st_nxt.standby      = st_r.cfg.pwr[`PWR_STANDBY_BIT]
                          | (shutdown_pin_i & pin_func);
    st_nxt.global_off   = st_r.cfg.pwr[`PWR_GLOBAL_BIT]
                          | (shutdown_pin_i & ~pin_func);
    st_nxt.swing_out    = st_r.cfg.swing;
    st_nxt.high_if_out  = st_r.cfg.high_if;
    st_nxt.sync_off_out = st_r.cfg.sync_off;
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  // synchronous reset clears every field, outputs included
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // ****************************************************************
  // sampling clock divider
  // ****************************************************************

  // the divide code takes effect on the cycle after the write lands;
  // the tick phase is not realigned when the code changes
  sample_clk_div u_div
  (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .div_code_i (st_r.cfg.clk_div),
    .tick_o     (div_tick)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************

  // every output is a flip-flop of the bank or of the divider
  assign wb_dat_o              = {24'h000000, st_r.rdata};
  assign wb_ack_o              = st_r.ack;
  assign chan_ctrl_o           = st_r.chan;
  assign converter_standby_o   = st_r.standby;
  assign global_shutdown_o     = st_r.global_off;
  assign swing_code_o          = st_r.swing_out;
  assign sample_en_o           = div_tick;
  assign high_if_mode_o        = st_r.high_if_out;
  assign sync_ref_buffer_off_o = st_r.sync_off_out;

endmodule

// ==== rtl/adc_cfg_regs.svh ====
`ifndef ADC_CFG_REGS_SVH
`define ADC_CFG_REGS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define IDX_W              12
`define REG_DITHER_PAIR    12'h001
`define REG_SOFT_RESET     12'h006
`define REG_PWR_CTRL       12'h015
`define REG_SWING          12'h025
`define REG_CLK_DIV        12'h027
`define REG_HIF_BIT0       12'h11d
`define REG_HIF_BIT1       12'h21d
`define REG_HIF_BIT2       12'h41d
`define REG_HIF_BIT3       12'h51d
`define REG_HIF_PAIR_LO    12'h308
`define REG_HIF_PAIR_HI    12'h608
`define REG_CHOP_A         12'h122
`define REG_CHOP_B         12'h422
`define REG_CHOP_C         12'h522
`define REG_CHOP_D         12'h222
`define REG_DITH_A         12'h134
`define REG_DITH_B         12'h434
`define REG_DITH_C         12'h534
`define REG_DITH_D         12'h234
`define REG_TWEAK_A        12'h139
`define REG_TWEAK_B        12'h439
`define REG_TWEAK_C        12'h539
`define REG_TWEAK_D        12'h239
`define REG_SYNC_REF       12'h70a

// ****************************************************************
// field positions
// ****************************************************************
`define PWR_CHAN_A_BIT     7
`define PWR_STANDBY_BIT    3
`define PWR_GLOBAL_BIT     2
`define PWR_PIN_FUNC_BIT   0
`define CLK_DIV_LSB        6
`define CHOP_BIT           1
`define DITH_HI_BIT        5
`define DITH_LO_BIT        3
`define TWEAK_BIT          3
`define HIF_SINGLE_BIT     1
`define HIF_PAIR_LSB       6
`define SYNC_OFF_BIT       0
`define SOFT_RESET_BIT     0

// ****************************************************************
// masks and reset value
// ****************************************************************
`define PWR_WRITE_MASK     8'hfd
`define PWR_READ_MASK      8'h6d
`define CFG_RESET_VAL      8'h00

`endif

// ==== rtl/adc_cfg_pkg.sv ====
package adc_cfg_pkg;

  // sampling clock divide codes
  typedef enum logic [1:0] {
    DIV_BY_1     = 2'b00,
    DIV_BY_1_ALT = 2'b01,
    DIV_BY_2     = 2'b10,
    DIV_BY_4     = 2'b11
  } clk_div_e;

  // per-channel controls, index 0..3 = channel a..d
  typedef struct packed {
    logic [3:0] shutdown;
    logic [3:0] chopper_off;
    logic [3:0] dither_off;
    logic [3:0] perf_tweak;
  } chan_ctrl_s;

  // software visible configuration
  typedef struct packed {
    logic [7:0] pwr;
    logic [7:0] swing;
    clk_div_e   clk_div;
    logic [7:0] high_if;
    logic [3:0] chop;
    logic [3:0] dith_hi;
    logic [3:0] dith_lo;
    logic [7:0] dith_pair;
    logic [3:0] tweak;
    logic       sync_off;
  } cfg_s;

  // whole state of the register bank
  typedef struct packed {
    cfg_s       cfg;
    logic       ack;
    logic [7:0] rdata;
    chan_ctrl_s chan;
    logic       standby;
    logic       global_off;
    logic [7:0] swing_out;
    logic [7:0] high_if_out;
    logic       sync_off_out;
  } bank_state_s;

  // state of the sampling clock divider
  typedef struct packed {
    logic [1:0] cnt;
    logic       tick;
  } div_state_s;

endpackage

// ==== rtl/sample_clk_div.sv ====
`timescale 1ns/10ps
module sample_clk_div
(
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // divide selection
  input  wire adc_cfg_pkg::clk_div_e  div_code_i,
  // divided rate as a one-cycle enable
  output logic                        tick_o
);

  adc_cfg_pkg::div_state_s st_r;
  adc_cfg_pkg::div_state_s st_nxt;

  // free running counter, tick picked from its low bits
  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.cnt = st_r.cnt + 2'h1;
    case (div_code_i)
      adc_cfg_pkg::DIV_BY_2: st_nxt.tick = st_r.cnt[0];
      adc_cfg_pkg::DIV_BY_4: st_nxt.tick = (st_r.cnt == 2'h3);
      default:               st_nxt.tick = 1'b1;
    endcase
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tick_o = st_r.tick;

endmodule

// ==== verification/adc_cfg_bank_chk.sv ====
`timescale 1ns/10ps
`include "adc_cfg_regs.svh"
module adc_cfg_bank_chk
(
  // clock and reset
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  // register bus
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [15:0]             wb_adr_i,
  input wire logic [3:0]              wb_sel_i,
  input wire logic [31:0]             wb_dat_i,
  input wire logic [31:0]             wb_dat_o,
  input wire logic                    wb_ack_o,
  // pin and converter controls
  input wire logic                    shutdown_pin_i,
  input wire adc_cfg_pkg::chan_ctrl_s chan_ctrl_o,
  input wire logic                    converter_standby_o,
  input wire logic                    global_shutdown_o,
  input wire logic [7:0]              swing_code_o,
  input wire logic                    sample_en_o,
  input wire logic [7:0]              high_if_mode_o,
  input wire logic                    sync_ref_buffer_off_o
);
  // ****************************************************************
  // shadow of the registers that drive outputs
  // ****************************************************************
  logic [11:0] idx;
  logic        wr;
  logic        srst;
  logic [3:0]  sd;
  logic [2:0]  exp_gap;
  logic [7:0]  pwr_r;
  logic [7:0]  sw_r;
  logic [1:0]  dv_r;
  logic        sy_r;
  logic [3:0]  stab_r;
  logic [2:0]  gap_r;
  // a write is taken only while no ack is pending
  assign idx = wb_adr_i[13:2];
  assign wr = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0];
  assign srst = wr & (idx == `REG_SOFT_RESET) & wb_dat_i[0];
  assign sd = {pwr_r[4], pwr_r[5], pwr_r[6], pwr_r[7]};
  assign exp_gap = dv_r[1] ? (dv_r[0] ? 3'h4 : 3'h2) : 3'h1;
  // shadow follows the same edge as the bank itself
  always_ff @(posedge clk_i)
  begin
    if (rst_i || srst)
    begin
      pwr_r <= 8'h00;
      sw_r <= 8'h00;
      dv_r <= 2'b00;
      sy_r <= 1'b0;
    end
    else if (wr)
    begin
      if (idx == `REG_PWR_CTRL) pwr_r <= wb_dat_i[7:0] & `PWR_WRITE_MASK;
      if (idx == `REG_SWING) sw_r <= wb_dat_i[7:0];
      if (idx == `REG_CLK_DIV) dv_r <= wb_dat_i[7:6];
      if (idx == `REG_SYNC_REF) sy_r <= wb_dat_i[0];
    end
  end
  // tick spacing is judged only once the code has been quiet a while,
  // since the divider phase runs free across code changes
  always_ff @(posedge clk_i)
  begin
    gap_r <= (rst_i || sample_en_o) ? 3'h1 : gap_r + {2'h0, gap_r != 3'h7};
    stab_r <= (rst_i || wr) ? 4'h0 : stab_r + {3'h0, stab_r != 4'hf};
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_chan_shutdown: assert property (
    !$past(rst_i) |-> chan_ctrl_o.shutdown == $past(sd))
    else $error("channel shutdown does not follow power control");
  a_power_read: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && idx == `REG_PWR_CTRL
    |=> wb_ack_o && wb_dat_o == {24'h0, pwr_r & `PWR_READ_MASK})
    else $error("power control read back wrong");
  a_standby_out: assert property (
    !$past(rst_i) |-> converter_standby_o == $past(pwr_r[3] | shutdown_pin_i & pwr_r[0]))
    else $error("standby output wrong");
  a_global_out: assert property (
    !$past(rst_i) |-> global_shutdown_o == $past(pwr_r[2] | shutdown_pin_i & ~pwr_r[0]))
    else $error("global shutdown output wrong");
  a_swing_copy: assert property (
    !$past(rst_i) |-> swing_code_o == $past(sw_r))
    else $error("swing code output wrong");
  a_tick_spacing: assert property (
    stab_r == 4'hf |-> gap_r <= exp_gap && (!sample_en_o || gap_r == exp_gap))
    else $error("sample enable spacing wrong");
  a_sync_buffer: assert property (
    !$past(rst_i) |-> sync_ref_buffer_off_o == $past(sy_r))
    else $error("sync reference buffer control wrong");
  a_soft_clear: assert property (
    srst |-> ##2 chan_ctrl_o == '0 && swing_code_o == 8'h00 && high_if_mode_o == 8'h00
    && !sync_ref_buffer_off_o)
    else $error("soft reset left controls set");
  a_reset_zero: assert property (
    $fell(rst_i) |-> chan_ctrl_o == '0 && swing_code_o == 8'h00 && !global_shutdown_o
    && !converter_standby_o && high_if_mode_o == 8'h00)
    else $error("controls not zero after reset");
  c_soft_reset: cover property (srst);
  c_div_four: cover property (sample_en_o && dv_r == 2'b11 && stab_r == 4'hf);
  c_pin_standby: cover property (shutdown_pin_i && converter_standby_o);
endmodule

bind adc_cfg_bank adc_cfg_bank_chk i_chk
(
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .shutdown_pin_i, .chan_ctrl_o, .converter_standby_o,
  .global_shutdown_o, .swing_code_o, .sample_en_o, .high_if_mode_o, .sync_ref_buffer_off_o
);

// ==== verification/test_adc_cfg_bank.sv ====
`timescale 1ns/10ps
`include "adc_cfg_regs.svh"
module test_adc_cfg_bank;
  // ****************************************************************
  // bench signals
  // ****************************************************************
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic                    wb_cyc_i = 1'b0;
  logic                    wb_stb_i = 1'b0;
  logic                    wb_we_i = 1'b0;
  logic [15:0]             wb_adr_i = 16'h0000;
  logic [3:0]              wb_sel_i = 4'h0;
  logic [31:0]             wb_dat_i = 32'h00000000;
  logic                    shutdown_pin_i = 1'b0;
  logic [31:0]             wb_dat_o;
  logic                    wb_ack_o;
  adc_cfg_pkg::chan_ctrl_s chan_ctrl_o;
  logic                    converter_standby_o;
  logic                    global_shutdown_o;
  logic [7:0]              swing_code_o;
  logic                    sample_en_o;
  logic [7:0]              high_if_mode_o;
  logic                    sync_ref_buffer_off_o;
  logic [34:0]             outs;
  logic [39:0]             exp_q[$];
  logic [31:0]             seed = 32'h0000cd7f;
  int                      n_mismatch = 0;
  int                      comparisons = 0;
  // register index and its readable bits
  logic [19:0] tbl[23] = '{20'h015_6d, 20'h025_ff, 20'h027_c0, 20'h11d_02, 20'h21d_02,
    20'h41d_02, 20'h51d_02, 20'h308_00, 20'h608_c0, 20'h122_02, 20'h422_02, 20'h522_02,
    20'h222_02, 20'h134_28, 20'h434_28, 20'h534_28, 20'h234_28, 20'h139_08, 20'h439_08,
    20'h539_08, 20'h239_08, 20'h70a_01, 20'h001_ff};
  logic [11:0] dith[4] = '{`REG_DITH_A, `REG_DITH_B, `REG_DITH_C, `REG_DITH_D};
  // power value, pin level, expected standby and global
  logic [11:0] pv[4] = '{12'h016, 12'h005, 12'h082, 12'h041};

  always #20 clk_i = ~clk_i;
  assign outs = {chan_ctrl_o, converter_standby_o, global_shutdown_o, swing_code_o,
                 high_if_mode_o, sync_ref_buffer_off_o};

  adc_cfg_bank i_dut
  (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .shutdown_pin_i, .chan_ctrl_o, .converter_standby_o,
    .global_shutdown_o, .swing_code_o, .sample_en_o, .high_if_mode_o, .sync_ref_buffer_off_o
  );

  // ****************************************************************
  // tasks
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // the request holds until ack is sampled; the slave gets no fixed latency
  task automatic bus(input logic we, input logic [11:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'h1;
    wb_adr_i <= {2'b00, ix, 2'b00};
    wb_dat_i <= {24'h000000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1)
    begin
      n_mismatch++;
      $display("[FAIL] %0t no acknowledge", $time);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] ix, input logic [7:0] d);
    bus(1'b1, ix, d);
  endtask
  task automatic rd(input logic [11:0] ix, input logic [7:0] e);
    exp_q.push_back({32'h00000000, e});
    bus(1'b0, ix, seed[7:0]);
  endtask
  task automatic settle();
    repeat (2) @(negedge clk_i);
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // checking processes and main sequence
  // ****************************************************************
  // read data is judged at the edge where its ack is sampled
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      chk({8'h00, wb_dat_o}, exp_q.pop_front());
  // a hung handshake must not stall the run
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    int n;
    logic [31:0] v;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({5'h00, outs}, 40'h0);
    foreach (tbl[i]) rd(tbl[i][19:8], 8'h00);
    // all ones in every field shows which bits are stored and which read back
    // only field bits are written, write-only fields included, the rest stay zero
    foreach (tbl[i])
    begin
      v[7:0] = (tbl[i][19:8] == `REG_PWR_CTRL) ? 8'hfd :
               ((tbl[i][19:8] == `REG_HIF_PAIR_LO) ? 8'hc0 : tbl[i][7:0]);
      wr(tbl[i][19:8], v[7:0]);
      rd(tbl[i][19:8], tbl[i][7:0]);
    end
    chk({5'h00, outs}, {5'h00, {35{1'b1}}});
    wr(12'h0ff, 8'hff);
    rd(12'h0ff, 8'h00);
    wr(`REG_SOFT_RESET, 8'h01);
    settle();
    chk({5'h00, outs}, 40'h0);
    rd(`REG_SOFT_RESET, 8'h00);
    rd(`REG_SWING, 8'h00);
    // one companion bit alone must not stop dither
    foreach (dith[c]) wr(dith[c], 8'h28);
    for (int c = 0; c < 4; c++)
    begin
      wr(`REG_DITHER_PAIR, 8'h80 >> (2 * c));
      wr(`REG_PWR_CTRL, 8'h80 >> c);
      settle();
      chk({32'h0, chan_ctrl_o.shutdown, chan_ctrl_o.dither_off}, {32'h0, 4'h1 << c, 4'h0});
      wr(`REG_DITHER_PAIR, 8'hc0 >> (2 * c));
      settle();
      chk({36'h0, chan_ctrl_o.dither_off}, {36'h0, 4'h1 << c});
    end
    foreach (pv[i])
    begin
      wr(`REG_PWR_CTRL, pv[i][11:4]);
      shutdown_pin_i <= pv[i][2];
      settle();
      chk({38'h0, converter_standby_o, global_shutdown_o}, {38'h0, pv[i][1:0]});
    end
    @(posedge clk_i);
    shutdown_pin_i <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      wr(`REG_CLK_DIV, {k[1:0], 6'h00});
      repeat (20) @(posedge clk_i);
      n = 0;
      repeat (16) @(posedge clk_i) n += int'(sample_en_o);
      chk(40'(n), (k < 2) ? 40'd16 : ((k == 2) ? 40'd8 : 40'd4));
    end
    repeat (4)
    begin
      v = rnd();
      wr(`REG_SWING, v[7:0]);
      rd(`REG_SWING, v[7:0]);
      chk({32'h0, swing_code_o}, {32'h0, v[7:0]});
    end
    stop_test();
  end
endmodule
